// ===== verilog/sar_ctrl_pkg.sv
// package for the successive-approximation converter control block
// assumes an AXI4-Lite master with 32-bit data and one 20 MHz bus clock
package sar_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h38;
	localparam logic [7:0] OFS_RESULT = 8'h3C;
	localparam logic [7:0] OFS_CLOCK_SELECT = 8'h40;
	// status/control and clock select fields
	localparam int DONE_POS = 7;
	localparam int IRQ_EN_POS = 6;
	localparam int CONT_POS = 5;
	localparam int CLK_SRC_POS = 7;
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1F;
	localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
	localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
	localparam logic [4:0] CHAN_SUPPLY_REF = 5'h1C;
	localparam logic [4:0] CHAN_HIGH_REF = 5'h1D;
	localparam logic [4:0] CHAN_LOW_REF = 5'h1E;
	localparam logic [4:0] CHAN_RESERVED = 5'h1B;
	// conversion length in converter clocks
	localparam logic [4:0] CONV_CYCLES = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic done_or_dma;
		logic irq_enable;
		logic continuous;
		logic [4:0] channel;
	} status_control_t;

	typedef struct packed {
		logic valid;
		logic is_port_d;
		logic [2:0] pin;
		logic [1:0] ref_sel;
	} mux_select_t;
endpackage : sar_ctrl_pkg

// ===== verilog/conv_tick_gen.sv
// converter clock tick generator: divides the selected input clock enable
// assumes the crystal clock arrives as a bus-synchronous enable pulse
`timescale 1ns/1ns
module conv_tick_gen
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic xtal_tick,
	input wire logic use_bus_clock,
	input wire logic [2:0] prescale,
	output logic tick
);
	logic [3:0] div_q;
	logic src_tick;
	logic [3:0] limit;

	assign src_tick = use_bus_clock ? 1'b1 : xtal_tick; // see R16

	always_comb
	begin
		case (prescale) // see R15
			3'h0: limit = 4'h0;
			3'h1: limit = 4'h1;
			3'h2: limit = 4'h3;
			3'h3: limit = 4'h7;
			default: limit = 4'hF;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_q <= 4'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (src_tick)
			begin
				if (div_q >= limit)
				begin
					div_q <= 4'h0;
					tick <= 1'b1;
				end
				else
				begin
					div_q <= div_q + 4'h1;
				end
			end
		end
	end
endmodule : conv_tick_gen

// ===== verilog/sar_converter_control_regs.sv
// register and sequencing logic of an 8-bit successive-approximation converter
// assumes the comparator delivers a sample word when a conversion ends
// Function
// R1 - with interrupts off, top status bit is read-only, set on each completion
// R2 - completion flag clears on status write or result read
// R3 - with interrupts on, top bit is writable: 1 DMA, 0 CPU
// R4 - reset clears top bit, interrupt enable and continuous bit
// R5 - interrupt enable raises a request at every conversion end
// R6 - pending request drops on result read or status write
// R7 - continuous bit repeats conversions, otherwise one conversion
// R8 - codes 0 to 7 pick port B inputs, 8 to 15 port D inputs
// R9 - codes 1C, 1D, 1E pick supply, high and low references
// R10 - all-ones channel code powers the converter off, reset value
// R11 - codes 10 to 1A unused give undefined result, 1B reserved
// R12 - reset sets every channel bit
// R13 - software waits one conversion after leaving power-off
// R14 - one 8-bit result register loaded at each completion
// R15 - 3-bit prescaler divides by 1, 2, 4, 8 or 16
// R16 - source bit 1 takes bus clock, 0 the crystal clock
// R17 - reset selects the crystal clock
// R18 - software keeps the converter clock near 1 MHz
// R19 - software keeps clock settings still during a conversion
// R20 - status write starts a conversion lasting 16 to 17 converter clocks
// R21 - stop mode aborts conversion, resumes after stop ends; the sequencer instead stays idle until the next status write
// R22 - result register writes have no effect
`timescale 1ns/1ns
module sar_converter_control_regs
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic xtal_tick,
	input wire logic stop_mode,
	input wire logic [7:0] sample_value,
	output sar_ctrl_pkg::mux_select_t mux_select_q,
	output logic converter_power_q,
	output logic converting_q,
	output logic cpu_irq_q,
	output logic dma_irq_q
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN = 2'b01
	} conv_state_t;

	conv_state_t state_q;
	sar_ctrl_pkg::status_control_t scr_q;
	logic [7:0] result_q;
	logic clk_src_q;
	logic [2:0] prescale_q;
	logic [4:0] count_q;
	logic irq_pend_q, tick, conv_done;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [31:0] awaddr_q, wdata_q;
	logic [3:0] wstrb_q;
	logic aw_held_q, w_held_q;
	logic do_write, wr_scr, wr_clk, wr_ok, rd_take, rd_result;

	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_scr = do_write && awaddr_q[7:0] == sar_ctrl_pkg::OFS_STATUS_CONTROL && wstrb_q[0];
	assign wr_clk = do_write && awaddr_q[7:0] == sar_ctrl_pkg::OFS_CLOCK_SELECT && wstrb_q[0];
	// result writes are accepted but change nothing
	assign wr_ok = awaddr_q[7:0] == sar_ctrl_pkg::OFS_STATUS_CONTROL
		|| awaddr_q[7:0] == sar_ctrl_pkg::OFS_CLOCK_SELECT
		|| awaddr_q[7:0] == sar_ctrl_pkg::OFS_RESULT; // see R22
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign rd_result = rd_take && s_axi_araddr[7:0] == sar_ctrl_pkg::OFS_RESULT;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 32'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sar_ctrl_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q <= s_axi_awaddr;
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? sar_ctrl_pkg::RESP_OKAY : sar_ctrl_pkg::RESP_SLVERR;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= sar_ctrl_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (rd_take)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= sar_ctrl_pkg::RESP_OKAY;
				case (s_axi_araddr[7:0])
					sar_ctrl_pkg::OFS_STATUS_CONTROL: s_axi_rdata <= {24'h0, scr_q};
					sar_ctrl_pkg::OFS_RESULT: s_axi_rdata <= {24'h0, result_q};
					sar_ctrl_pkg::OFS_CLOCK_SELECT: s_axi_rdata <= {24'h0, clk_src_q, 4'h0, prescale_q};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= sar_ctrl_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			scr_q <= sar_ctrl_pkg::STATUS_CONTROL_RESET; // see R4 R12 R10
		else
		begin
			if (wr_scr)
			begin
				scr_q.irq_enable <= wdata_q[sar_ctrl_pkg::IRQ_EN_POS];
				scr_q.continuous <= wdata_q[sar_ctrl_pkg::CONT_POS];
				scr_q.channel <= wdata_q[4:0];
			end
			// top bit: flag when interrupts off, service select when on
			if (scr_q.irq_enable)
			begin
				if (wr_scr)
					scr_q.done_or_dma <= wdata_q[sar_ctrl_pkg::DONE_POS]; // see R3
			end
			else if (conv_done)
				scr_q.done_or_dma <= 1'b1; // see R1
			else if (wr_scr || rd_result)
				scr_q.done_or_dma <= 1'b0; // see R2
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			clk_src_q <= 1'b0; // see R17
			prescale_q <= 3'h0;
		end
		else if (wr_clk)
		begin
			clk_src_q <= wdata_q[sar_ctrl_pkg::CLK_SRC_POS];
			prescale_q <= wdata_q[2:0];
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	conv_tick_gen u_tick
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.xtal_tick(xtal_tick),
		.use_bus_clock(clk_src_q),
		.prescale(prescale_q),
		.tick(tick)
	);

	logic powered;
	assign powered = scr_q.channel != sar_ctrl_pkg::CHAN_POWER_OFF; // see R10
	// the start falls between ticks, so ending on the 17th tick gives 16 to 17 full converter periods
	assign conv_done = state_q == CONV_RUN && tick && count_q == sar_ctrl_pkg::CONV_CYCLES; // see R20

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= CONV_IDLE;
			count_q <= 5'h0;
			converting_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				CONV_IDLE:
				begin
					if (wr_scr && !stop_mode && wdata_q[4:0] != sar_ctrl_pkg::CHAN_POWER_OFF)
					begin
						state_q <= CONV_RUN; // see R20
						count_q <= 5'h0;
						converting_q <= 1'b1;
					end
				end
				CONV_RUN:
				begin
					if (stop_mode || !powered)
					begin
						state_q <= CONV_IDLE; // see R21
						converting_q <= 1'b0;
					end
					else if (wr_scr)
						count_q <= 5'h0;
					else if (conv_done)
					begin
						count_q <= 5'h0;
						if (!scr_q.continuous)
						begin
							state_q <= CONV_IDLE; // see R7
							converting_q <= 1'b0;
						end
					end
					else if (tick)
						count_q <= count_q + 5'h1;
				end
				default:
				begin
					state_q <= CONV_IDLE;
					converting_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			result_q <= 8'h00;
		else if (conv_done)
			result_q <= sample_value; // see R14
	end

	// ----------------------------------------
	// interrupt request and mux
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_pend_q <= 1'b0;
			cpu_irq_q <= 1'b0;
			dma_irq_q <= 1'b0;
		end
		else
		begin
			if (conv_done && scr_q.irq_enable)
				irq_pend_q <= 1'b1; // see R5
			else if (wr_scr || rd_result || !scr_q.irq_enable)
				irq_pend_q <= 1'b0; // see R6
			cpu_irq_q <= irq_pend_q && scr_q.irq_enable && !scr_q.done_or_dma; // see R3
			dma_irq_q <= irq_pend_q && scr_q.irq_enable && scr_q.done_or_dma;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mux_select_q <= '0;
			converter_power_q <= 1'b0;
		end
		else
		begin
			converter_power_q <= powered;
			mux_select_q.is_port_d <= scr_q.channel[3]; // see R8
			mux_select_q.pin <= scr_q.channel[2:0];
			// unused and reserved codes leave no path, so the result is undefined
			mux_select_q.valid <= !scr_q.channel[4]; // see R11
			case (scr_q.channel)
				sar_ctrl_pkg::CHAN_SUPPLY_REF: mux_select_q.ref_sel <= 2'h1; // see R9
				sar_ctrl_pkg::CHAN_HIGH_REF: mux_select_q.ref_sel <= 2'h2;
				sar_ctrl_pkg::CHAN_LOW_REF: mux_select_q.ref_sel <= 2'h3;
				default: mux_select_q.ref_sel <= 2'h0;
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_flag_set_done: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && !scr_q.irq_enable |=> scr_q.done_or_dma) // see R1
		else $error("completion flag not set");
	a_flag_clear_access: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_scr || rd_result) && !conv_done && !scr_q.irq_enable |=> !scr_q.done_or_dma) // see R2
		else $error("completion flag not cleared");
	a_irq_raise_done: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && scr_q.irq_enable && !wr_scr |=> ##1 (cpu_irq_q || dma_irq_q)) // see R5
		else $error("interrupt not raised");
	a_irq_drop_access: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_scr || rd_result) && !conv_done |=> ##1 !(cpu_irq_q || dma_irq_q)) // see R6
		else $error("interrupt not dropped");
	a_irq_route_target: assert property (@(posedge aclk) disable iff (!aresetn)
		dma_irq_q |-> $past(scr_q.done_or_dma)) // see R3
		else $error("interrupt misrouted");
	a_single_shot_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && !scr_q.continuous && !stop_mode && !wr_scr |=> state_q == CONV_IDLE) // see R7
		else $error("single conversion did not stop");
	a_result_load_done: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done |=> result_q == $past(sample_value)) // see R14
		else $error("result not loaded");
	a_stop_abort_run: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mode |=> !converting_q) // see R21
		else $error("conversion not aborted");
	a_power_off_code: assert property (@(posedge aclk) disable iff (!aresetn)
		scr_q.channel == sar_ctrl_pkg::CHAN_POWER_OFF |=> !converter_power_q) // see R10
		else $error("converter not powered off");
	c_single_done: cover property (@(posedge aclk) disable iff (!aresetn) conv_done && !scr_q.continuous);
	c_cont_done: cover property (@(posedge aclk) disable iff (!aresetn) conv_done && scr_q.continuous);
	c_dma_irq: cover property (@(posedge aclk) disable iff (!aresetn) dma_irq_q);
endmodule : sar_converter_control_regs

// ===== verification/analog_front_model.sv
// model of the analog side: channel multiplexer, comparator word and crystal enable
// assumes the crystal runs free and is seen as a one-cycle enable on the bus clock
`timescale 1ns/1ns
module analog_front_model
#(
	parameter int XTAL_DIV = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire sar_ctrl_pkg::mux_select_t mux_select_q,
	input wire logic converter_power_q,
	output logic xtal_tick,
	output logic [7:0] sample_value
);
	// ----------------------------------------
	// crystal enable
	// ----------------------------------------
	logic [7:0] xtal_cnt_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || xtal_cnt_q == 8'(XTAL_DIV - 1))
			xtal_cnt_q <= 8'h00;
		else
			xtal_cnt_q <= xtal_cnt_q + 8'h01;
	end

	assign xtal_tick = (xtal_cnt_q == 8'h00);

	// ----------------------------------------
	// comparator word
	// ----------------------------------------
	// no input selected: the word keeps changing so a stale value never looks valid
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sample_value <= 8'h00;
		else if (converter_power_q && mux_select_q.ref_sel != 2'h0)
			sample_value <= {2'h2, mux_select_q.ref_sel, 4'h0};
		else if (converter_power_q && mux_select_q.valid)
			sample_value <= {4'h8, mux_select_q.is_port_d, mux_select_q.pin};
		else
			sample_value <= ~sample_value;
	end
endmodule : analog_front_model

// ===== verification/test_sar_converter_control_regs.sv
// self-checking bench of the converter control block over its register bus
// assumes the analog front model on the far side and a 20 MHz bus clock
`timescale 1ns/1ns
module test_sar_converter_control_regs;
	localparam logic [7:0] st_ofs = sar_ctrl_pkg::OFS_STATUS_CONTROL;
	localparam logic [7:0] res_ofs = sar_ctrl_pkg::OFS_RESULT;
	localparam logic [7:0] clk_ofs = sar_ctrl_pkg::OFS_CLOCK_SELECT;
	typedef struct packed {logic [4:0] ch; logic [6:0] mux; logic pwr; logic [7:0] res;} row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, xtal_tick, stop_mode;
	logic converter_power_q, converting_q, cpu_irq_q, dma_irq_q;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] sample_value;
	sar_ctrl_pkg::mux_select_t mux_select_q;
	row_t rows[8];
	int fail_count, total_checks, n, dv;

	sar_converter_control_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .xtal_tick, .stop_mode, .sample_value, .mux_select_q,
		.converter_power_q, .converting_q, .cpu_irq_q, .dma_irq_q);
	analog_front_model #(.XTAL_DIV(4)) far_side (.aclk, .aresetn, .mux_select_q, .converter_power_q,
		.xtal_tick, .sample_value);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_ok, w_ok;
		@(posedge aclk);
		{aw_ok, w_ok} = 2'b00;
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1)
			begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
			if (s_axi_awready === 1'b1 && !aw_ok)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !w_ok)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		fail_count++;
		print_verdict();
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		logic ar_ok;
		@(posedge aclk);
		ar_ok = 1'b0;
		s_axi_araddr <= {24'h000000, a};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1)
			begin
				{rd, resp} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
				return;
			end
			if (s_axi_arready === 1'b1 && !ar_ok)
			begin
				ar_ok = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		fail_count++;
		print_verdict();
	endtask : rd_reg

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] want);
		rd_reg(a);
		check(rd, {24'h000000, want});
	endtask : chk_rd

	// counts bus cycles until the running conversion ends
	task automatic wait_idle;
		n = 0;
		while (converting_q === 1'b1)
		begin
			@(posedge aclk);
			n++;
			if (n > 3000)
			begin
				fail_count++;
				print_verdict();
			end
		end
	endtask : wait_idle

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stop_mode} = 7'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		{fail_count, total_checks} = 64'h0;
		rows = '{'{5'h00, 7'h40, 1'b1, 8'h80}, '{5'h07, 7'h5C, 1'b1, 8'h87}, '{5'h08, 7'h60, 1'b1, 8'h88},
			'{5'h0F, 7'h7C, 1'b1, 8'h8F}, '{5'h1C, 7'h01, 1'b1, 8'h90}, '{5'h1D, 7'h02, 1'b1, 8'hA0},
			'{5'h1E, 7'h03, 1'b1, 8'hB0}, '{5'h1F, 7'h00, 1'b0, 8'h00}};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// bus clock over 16 gives a 1.25 MHz converter clock
		wr(clk_ofs, 8'h84);
		chk_rd(clk_ofs, 8'h84);
		// first result after power-up is thrown away while the analog side settles
		wr(st_ofs, 8'h00);
		wait_idle();
		rd_reg(res_ofs);
		foreach (rows[i])
		begin
			wr(st_ofs, {3'b000, rows[i].ch});
			// power and mux outputs follow the new channel one edge after the response
			@(posedge aclk);
			check(32'(converter_power_q), 32'(rows[i].pwr));
			check(32'({mux_select_q.valid, mux_select_q.ref_sel}), 32'({rows[i].mux[6], rows[i].mux[1:0]}));
			if (rows[i].ch < 5'h10)
				check(32'(mux_select_q[5:2]), 32'(rows[i].mux[5:2]));
			wait_idle();
			chk_rd(st_ofs, {rows[i].pwr, 2'b00, rows[i].ch});
			if (rows[i].pwr)
				chk_rd(res_ofs, rows[i].res);
			chk_rd(st_ofs, {3'b000, rows[i].ch});
		end

		// ----------------------------------------
		// awkward cases
		// ----------------------------------------
		// clock settings only change between conversions
		for (int p = 0; p < 7; p++)
		begin
			wr(clk_ofs, (p == 6) ? 8'h00 : 8'h80 | 8'(p));
			dv = (p == 6) ? 4 : (p >= 4) ? 16 : (1 << p);
			wr(st_ofs, 8'h00);
			wait_idle();
			check(32'(n > 16 * dv && n <= 17 * dv), 32'h1);
			rd_reg(res_ofs);
		end
		wr(clk_ofs, 8'h84);
		repeat (40) @(posedge aclk);
		check(32'(converting_q), 32'h0);
		wr(st_ofs, 8'h20);
		// long enough for two conversions at the divided clock
		repeat (600) @(posedge aclk);
		check(32'(converting_q), 32'h1);
		chk_rd(st_ofs, 8'hA0);
		// restarting first keeps a completion away from the enabling write
		wr(st_ofs, 8'h00);
		wr(st_ofs, 8'h40);
		wait_idle();
		repeat (2) @(posedge aclk);
		check(32'({cpu_irq_q, dma_irq_q}), 32'h2);
		chk_rd(st_ofs, 8'h40);
		chk_rd(res_ofs, 8'h80);
		@(posedge aclk);
		check(32'(cpu_irq_q), 32'h0);
		wr(st_ofs, 8'hC0);
		wait_idle();
		repeat (2) @(posedge aclk);
		check(32'({cpu_irq_q, dma_irq_q}), 32'h1);
		wr(st_ofs, 8'hDF);
		@(posedge aclk);
		check(32'(dma_irq_q), 32'h0);
		chk_rd(st_ofs, 8'hDF);
		wr(st_ofs, 8'h00);
		repeat (4) @(posedge aclk);
		stop_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		check(32'(converting_q), 32'h0);
		chk_rd(st_ofs, 8'h00);
		stop_mode <= 1'b0;
		wr(res_ofs, 8'h55);
		check(32'(resp), 32'(sar_ctrl_pkg::RESP_OKAY));
		chk_rd(res_ofs, 8'h80);
		chk_rd(8'h44, 8'h00);
		check(32'(resp), 32'(sar_ctrl_pkg::RESP_SLVERR));
		wr(st_ofs, 8'h1B);
		@(posedge aclk);
		check(32'({converter_power_q, mux_select_q.valid, mux_select_q.ref_sel}), 32'h8);
		wr(st_ofs, 8'hE3);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		check(32'(converter_power_q), 32'h0);
		chk_rd(st_ofs, 8'h1F);
		chk_rd(clk_ofs, 8'h00);
		chk_rd(res_ofs, 8'h00);
		print_verdict();
	end
endmodule : test_sar_converter_control_regs
